// ===== rtl/srb_bus_config.sv
// strobe region configuration registers, wait states and lane strobes
//
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none
// Operation
// - three-bit wait count, 0 to 7 phase cycles, resets to 111
// - five-bit bank compare field in both strobe regions, resets 10000
// - data size field at bits 17:16, 00/01/11 for 8/16/32, resets 11
// - strap low loads width 11, strap high loads width 01 at reset
// - two-bit physical width field per strobe region, separate from size
// - wait mode field with wait count selects wait generation, resets 11
// - width decode 00 8-bit, 01 16-bit, 10 reserved, 11 32-bit
// - at 32-bit four byte enables; 16-bit: lane 3 carries address, lane 2 high; 8-bit: lanes 3-2 address, lane 1 high
module srb_bus_config (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic [7:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic i_width_strap_pin, // width strap pin, async
  input wire logic i_ext_ready_n, // external ready pin, async, low ready
  input wire logic [2:0] i_region_start, // access start pulse per region
  input wire logic [1:0] i_region_sel, // strobe region access in progress
  input wire logic i_ext_access, // any external access in progress
  input wire logic [3:0] i_lane_en, // requested byte lanes, high active
  input wire logic [1:0] i_sub_addr, // sub-word address bits A-1, A-2
  output logic [2:0] o_region_ready, // wait done pulse per region
  output logic [3:0] o_primary_region_strobe_n, // primary lane strobes
  output logic [3:0] o_secondary_region_strobe_n, // secondary lane strobes
  output logic [9:0] o_bank_compare_bits, // bank field, secondary high
  output logic [3:0] o_data_size // size field, secondary high
);
  logic [31:0] cfg_q [3];
  logic strap_meta_q;
  logic strap_sync_q;
  logic rdy_meta_q;
  logic rdy_sync_q;
  logic init_done_q;
  logic [3:0] lane_q [2];

  // strap and ready synchronisers; no reset so the strap survives reset
  always_ff @(posedge i_clk) begin
    strap_meta_q <= i_width_strap_pin;
    strap_sync_q <= strap_meta_q;
    rdy_meta_q <= i_ext_ready_n;
    rdy_sync_q <= rdy_meta_q;
  end

  // strap is sampled on the first edge after reset release
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_region
      localparam logic [7:0] OFF = (g == 0) ? srb_pkg::OFF_PRIMARY_CTRL :
        (g == 1) ? srb_pkg::OFF_SECONDARY_CTRL : srb_pkg::OFF_IO_CTRL;
      localparam logic [31:0] RST = (g == 2) ? srb_pkg::RST_IO_CTRL :
        srb_pkg::RST_STRB_CTRL;
      localparam logic [31:0] MASK = (g == 2) ? srb_pkg::MASK_IO_CTRL :
        srb_pkg::MASK_STRB_CTRL;
      srb_pkg::srb_wait_e st_q;
      logic [2:0] cnt_q;
      logic int_done;
      logic go;
      logic [1:0] wmode;

      // reset to fixed values, width field from the strap after release
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          cfg_q[g] <= RST;
        end else if (!init_done_q && g != 2) begin
          cfg_q[g][srb_pkg::PWIDTH_MSB:srb_pkg::PWIDTH_LSB] <=
            strap_sync_q ? srb_pkg::WIDTH_16 : srb_pkg::WIDTH_32;
        end else if (i_wr && i_addr == OFF) begin
          // reserved bits and io-only gaps stay zero
          cfg_q[g] <= i_wdata & MASK;
        end
      end

      assign wmode = cfg_q[g][srb_pkg::WMODE_MSB:srb_pkg::WMODE_LSB];
      assign int_done = (cnt_q == 3'h0);

      // ready combination per wait mode
      always_comb begin
        case (wmode)
          srb_pkg::WMODE_EXT: go = !rdy_sync_q;
          srb_pkg::WMODE_INT: go = int_done;
          srb_pkg::WMODE_BOTH: go = int_done && !rdy_sync_q;
          srb_pkg::WMODE_EITHER: go = int_done || !rdy_sync_q;
          default: go = 1'b1;
        endcase
      end

      // one clock stands for one phase cycle of wait
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          st_q <= srb_pkg::WS_IDLE;
          cnt_q <= 3'h0;
          o_region_ready[g] <= 1'b0;
        end else begin
          o_region_ready[g] <= 1'b0;
          case (st_q)
            srb_pkg::WS_IDLE: begin
              if (i_region_start[g]) begin
                cnt_q <=
                  cfg_q[g][srb_pkg::WCNT_MSB:srb_pkg::WCNT_LSB];
                st_q <= srb_pkg::WS_WAIT;
              end
            end
            srb_pkg::WS_WAIT: begin
              if (go) begin
                o_region_ready[g] <= 1'b1;
                st_q <= srb_pkg::WS_IDLE;
              end else if (!int_done) begin
                cnt_q <= cnt_q - 3'h1;
              end
            end
            default: st_q <= srb_pkg::WS_IDLE;
          endcase
        end
      end
    end

    for (g = 0; g < 2; g++) begin : g_lane
      logic [1:0] width;
      logic [3:0] be_n;
      logic [3:0] lane_d;
      assign width = cfg_q[g][srb_pkg::PWIDTH_MSB:srb_pkg::PWIDTH_LSB];
      assign be_n = i_region_sel[g] ? ~i_lane_en : 4'hF;

      always_comb begin
        case (width)
          srb_pkg::WIDTH_8: begin
            lane_d = {i_ext_access ? i_sub_addr[0] : 1'b1,
                      i_ext_access ? i_sub_addr[1] : 1'b1,
                      1'b1, be_n[0]};
          end
          srb_pkg::WIDTH_16: begin
            lane_d = {i_ext_access ? i_sub_addr[0] : 1'b1,
                      1'b1, be_n[1:0]};
          end
          // reserved encoding behaves as full width
          default: lane_d = be_n;
        endcase
      end

      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          lane_q[g] <= 4'hF;
        end else begin
          lane_q[g] <= lane_d;
        end
      end
    end
  endgenerate

  assign o_primary_region_strobe_n = lane_q[0];
  assign o_secondary_region_strobe_n = lane_q[1];

  // field outputs are registered copies, so they lag a write by one cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bank_compare_bits <= {2{srb_pkg::RST_STRB_CTRL[12:8]}};
      o_data_size <= {2{srb_pkg::RST_STRB_CTRL[17:16]}};
    end else begin
      o_bank_compare_bits <= {cfg_q[1][12:8], cfg_q[0][12:8]};
      o_data_size <= {cfg_q[1][17:16], cfg_q[0][17:16]};
    end
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        srb_pkg::OFF_PRIMARY_CTRL: o_rdata <= cfg_q[0];
        srb_pkg::OFF_SECONDARY_CTRL: o_rdata <= cfg_q[1];
        srb_pkg::OFF_IO_CTRL: o_rdata <= cfg_q[2];
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ===== pkg/srb_pkg.sv
// shared constants for the strobe region bus configuration block
`default_nettype none
package srb_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned N_REGION = 3;
  localparam int unsigned N_LANE = 4;
  // region indices: 0 primary, 1 secondary, 2 io
  localparam int unsigned REG_PRIMARY = 0;
  localparam int unsigned REG_SECONDARY = 1;
  localparam int unsigned REG_IO = 2;
  // register byte offsets
  localparam logic [7:0] OFF_IO_CTRL = 8'h60;
  localparam logic [7:0] OFF_PRIMARY_CTRL = 8'h64;
  localparam logic [7:0] OFF_SECONDARY_CTRL = 8'h68;
  // field positions
  localparam int unsigned WMODE_LSB = 3;
  localparam int unsigned WMODE_MSB = 4;
  localparam int unsigned WCNT_LSB = 5;
  localparam int unsigned WCNT_MSB = 7;
  localparam int unsigned BANK_LSB = 8;
  localparam int unsigned BANK_MSB = 12;
  localparam int unsigned DSIZE_LSB = 16;
  localparam int unsigned DSIZE_MSB = 17;
  localparam int unsigned PWIDTH_LSB = 18;
  localparam int unsigned PWIDTH_MSB = 19;
  // reset values; width field later reloaded from the strap
  localparam logic [31:0] RST_STRB_CTRL = 32'h000F10F8;
  localparam logic [31:0] RST_IO_CTRL = 32'h000000F8;
  localparam logic [31:0] MASK_STRB_CTRL = 32'h000F1FF8;
  localparam logic [31:0] MASK_IO_CTRL = 32'h000000F8;
  // width encodings
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_RSVD = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;
  // wait mode encodings
  localparam logic [1:0] WMODE_EXT = 2'h0;
  localparam logic [1:0] WMODE_INT = 2'h1;
  localparam logic [1:0] WMODE_BOTH = 2'h2;
  localparam logic [1:0] WMODE_EITHER = 2'h3;
  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_WAIT = 2'b10
  } srb_wait_e;
endpackage
`default_nettype wire

// ===== tb/srb_mem_model.sv
// external memory model answering strobe-selected accesses
`default_nettype none
module srb_mem_model (
  input wire logic i_clk, // clock
  input wire logic [3:0] i_strobe_n, // lane strobes, low active
  input wire logic i_slow, // answer three cycles later
  output logic o_ready_n // ready, low active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sh_q = 4'h0;
  // no access, no ready: a stale ready would hide waits
  always @(posedge i_clk) sh_q <= {sh_q[2:0], ~&i_strobe_n};
  assign o_ready_n = ~(i_slow ? sh_q[3] : sh_q[0]);
endmodule
`default_nettype wire

// ===== tb/srb_bus_config_monitor.sv
// concurrent checks on the configuration block ports
`default_nettype none
module srb_bus_config_monitor (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset, low active
  input wire logic [7:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [31:0] o_rdata, // read data
  input wire logic [1:0] i_region_sel, // region select
  input wire logic i_ext_access, // external access
  input wire logic [3:0] i_lane_en, // lanes wanted
  input wire logic [2:0] o_region_ready, // wait done
  input wire logic [3:0] o_primary_region_strobe_n, // primary lanes
  input wire logic [3:0] o_secondary_region_strobe_n, // secondary lanes
  input wire logic [9:0] o_bank_compare_bits, // bank fields
  input wire logic [3:0] o_data_size // size fields
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rst_size;
    $rose(i_rst_n) |-> o_data_size == 4'hF;
  endproperty
  a_rst_size: assert property (p_rst_size)
    else $error("size reset");
  property p_rst_bank;
    $rose(i_rst_n) |-> o_bank_compare_bits == 10'h210;
  endproperty
  a_rst_bank: assert property (p_rst_bank)
    else $error("bank reset");
  property p_lane_p;
    (!i_region_sel[0] || i_lane_en == 4'h0) && !i_ext_access
      |=> o_primary_region_strobe_n == 4'hF;
  endproperty
  a_lane_p: assert property (p_lane_p)
    else $error("primary lanes");
  property p_lane_s;
    !i_region_sel[1] && !i_ext_access
      |=> o_secondary_region_strobe_n == 4'hF;
  endproperty
  a_lane_s: assert property (p_lane_s)
    else $error("second lanes");
  property p_rd_mask;
    i_rd |=> (o_rdata & ~srb_pkg::MASK_STRB_CTRL) == 32'h0;
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("read mask");
  property p_wr_size;
    i_wr && i_addr == srb_pkg::OFF_PRIMARY_CTRL ##1 !i_wr
      |-> ##1 o_data_size[1:0] == $past(i_wdata[17:16], 2);
  endproperty
  a_wr_size: assert property (p_wr_size)
    else $error("size out");
  property p_wr_bank;
    i_wr && i_addr == srb_pkg::OFF_SECONDARY_CTRL ##1 !i_wr
      |-> ##1 o_bank_compare_bits[9:5] == $past(i_wdata[12:8], 2);
  endproperty
  a_wr_bank: assert property (p_wr_bank)
    else $error("bank out");
  property p_rdy;
    o_region_ready[0] |=> !o_region_ready[0];
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready pulse");
endmodule
bind srb_bus_config srb_bus_config_monitor srb_bus_config_monitor_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_region_sel(i_region_sel), .i_ext_access(i_ext_access),
  .i_lane_en(i_lane_en), .o_region_ready(o_region_ready),
  .o_primary_region_strobe_n(o_primary_region_strobe_n),
  .o_secondary_region_strobe_n(o_secondary_region_strobe_n),
  .o_bank_compare_bits(o_bank_compare_bits), .o_data_size(o_data_size)
);
`default_nettype wire

// ===== tb/tb_top.sv
// register, lane and wait-state tests for the configuration block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_wr, i_rd, i_width_strap_pin, i_ext_ready_n;
  logic i_ext_access, mem_slow;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0] i_region_start, o_region_ready;
  logic [1:0] i_region_sel, i_sub_addr;
  logic [3:0] i_lane_en, o_data_size, o_primary_region_strobe_n;
  logic [3:0] o_secondary_region_strobe_n;
  logic [9:0] o_bank_compare_bits;
  logic [1:0] ws[3] = '{2'h3, 2'h1, 2'h0};
  logic [3:0] ls[3] = '{4'h0, 4'hC, 4'hA};
  // mode, count, select, expected cycles (0: any pulse, 40: none)
  // no-ready case last: it leaves the primary wait machine parked
  logic [19:0] wtab[6] = '{20'h10001, 20'h20100, 20'h23104, 20'h17008,
    20'h37008, 20'h00028};
  int error_cnt = 0, n_compared = 0, cyc = 0, c;
  srb_bus_config srb_bus_config_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_width_strap_pin(i_width_strap_pin), .i_ext_ready_n(i_ext_ready_n),
    .i_region_start(i_region_start), .i_region_sel(i_region_sel),
    .i_ext_access(i_ext_access), .i_lane_en(i_lane_en),
    .i_sub_addr(i_sub_addr), .o_region_ready(o_region_ready),
    .o_primary_region_strobe_n(o_primary_region_strobe_n),
    .o_secondary_region_strobe_n(o_secondary_region_strobe_n),
    .o_bank_compare_bits(o_bank_compare_bits), .o_data_size(o_data_size)
  );
  srb_mem_model srb_mem_model_inst (.i_clk(i_clk),
    .i_strobe_n(o_primary_region_strobe_n), .i_slow(mem_slow),
    .o_ready_n(i_ext_ready_n));
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  // strap held through reset so the synchroniser settles
  task automatic rst(logic s);
    i_rst_n <= 1'b0;
    i_width_strap_pin <= s;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic wt(logic [3:0] m, logic [3:0] n, logic s);
    @(posedge i_clk) i_region_sel <= {1'b0, s};
    wr(8'h64, 32'(32'h000F1000 | {n[2:0], m[1:0], 3'h0}));
    @(posedge i_clk) i_region_start <= 3'h1;
    @(posedge i_clk) i_region_start <= 3'h0;
    c = 0;
    #1;
    while (o_region_ready[0] !== 1'b1 && c < 40) begin
      @(posedge i_clk);
      #1 c++;
    end
  endtask
  initial begin
    {i_rst_n, i_wr, i_rd, i_ext_access, mem_slow} = 5'h0;
    {i_width_strap_pin, i_addr, i_wdata} = 41'h0;
    {i_region_start, i_region_sel, i_sub_addr, i_lane_en} = 11'h00F;
    rst(1'b1);
    rd(8'h64, 32'h000710F8);
    @(posedge i_clk) rst(1'b0);
    rd(8'h64, 32'h000F10F8);
    rd(8'h68, 32'h000F10F8);
    rd(8'h60, 32'h000000F8);
    wr(8'h68, 32'hFFFFFFFF);
    rd(8'h68, 32'h000F1FF8);
    chk("bank", 32'h000003F0, 32'(o_bank_compare_bits));
    wr(8'h6C, 32'hFFFFFFFF);
    rd(8'h6C, 32'h0);
    wr(8'h64, 32'h000D10F8);
    rd(8'h64, 32'h000D10F8);
    chk("size", 32'hD, 32'(o_data_size));
    @(posedge i_clk);
    i_region_sel <= 2'h3;
    {i_ext_access, i_sub_addr} <= 3'h5;
    for (int k = 0; k < 3; k++) begin
      wr(8'h64, {12'h0, ws[k], 18'h310F8});
      repeat (2) @(posedge i_clk);
      #1 chk("lanes", 32'(ls[k]),
        32'(o_primary_region_strobe_n));
      chk("lanes2", 32'h0, 32'(o_secondary_region_strobe_n));
    end
    @(posedge i_clk) {i_ext_access, mem_slow} <= 2'h1;
    for (int k = 0; k < 6; k++) begin
      wt(wtab[k][19:16], wtab[k][15:12], wtab[k][8]);
      if (wtab[k][7:0] != 8'h0) begin
        chk("wait", 32'(wtab[k][7:0]), c);
      end else begin
        chk("ext wait", 32'h1, 32'(c < 40));
      end
    end
    print_verdict;
  end
endmodule
`default_nettype wire
